// File: design/eesel_slave.sv
// Purpose: Slave front end of a two-wire serial EEPROM: select, address, ack.
// Assumes: scl_link is the bus clock pin; ref_clk runs free at 40 MHz.
// Notes: Read data and the internal write cycle live outside this block.
`timescale 1ns/100ps

module eesel_slave #(
    parameter logic [3:0] DEV_TYPE_MEM = 4'h5, // Arbitrary value
    parameter logic [3:0] DEV_TYPE_ID = 4'h6, // Arbitrary value
    parameter bit HAS_ID_PAGE = 1'b1,
    parameter int MEM_ADDR_W = 16
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic scl_link,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic chip_sel_strap_0,
    input wire logic chip_sel_strap_1,
    input wire logic chip_sel_strap_2,
    input wire logic write_protect_in,
    input wire logic write_busy,
    output logic standby,
    output logic wr_valid,
    output eesel_pkg::eesel_wr_s wr_cmd
);
    import eesel_pkg::*;

    localparam logic [15:0] ADDR_MASK = 16'((32'h1 << MEM_ADDR_W) - 32'h1);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [1:0] pin_s;
    logic [1:0] pin_d;
    logic start_det;
    logic stop_det;
    logic start_ok;
    logic [1:0] pulse_cnt;
    logic hold_link;
    logic link_rst;
    logic [1:0] back_s;
    logic tgl_d;
    logic wr_evt;
    logic [3:0] bit_cnt;
    logic [6:0] shreg;
    logic [7:0] rx_byte;
    logic byte_done;
    eesel_link_e state;
    logic [3:0] strap_wp_s;
    logic [2:0] strap_s;
    logic wp_s;
    logic cs_match;
    logic type_mem;
    logic type_id;
    logic sel_hit;
    logic ack_pend;
    logic id_page;
    logic [15:0] addr;
    logic deselect;
    logic xfer_tgl;
    eesel_wr_s xfer_hold;

    // ****************************************************************
    // Bus condition detection (system clock)
    // ****************************************************************
    eesel_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_pin_sync (
        .clk(ref_clk),
        .rst(sys_rst),
        .d({scl_link, sda_in}),
        .q(pin_s)
    );

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_d <= 2'h3;
        end else begin
            pin_d <= pin_s;
        end
    end

    // Clock must be high on both samples so a data change just after
    // the clock falls is never mistaken for a bus condition.
    assign start_det = pin_s[1] & pin_d[1] & pin_d[0] & ~pin_s[0];
    assign stop_det = pin_s[1] & pin_d[1] & ~pin_d[0] & pin_s[0];
    assign start_ok = start_det & ~write_busy;

    // ****************************************************************
    // Frame state and link hold (system clock)
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            standby <= 1'b1;
        end else if (stop_det) begin
            standby <= 1'b1;
        end else if (start_ok) begin
            standby <= 1'b0;
        end else if (back_s[0]) begin
            standby <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pulse_cnt <= 2'h0;
        end else if (start_ok) begin
            pulse_cnt <= FRAME_PULSE_CYC;
        end else if (pulse_cnt != 2'h0) begin
            pulse_cnt <= pulse_cnt - 2'h1;
        end
    end

    // Link logic is held in reset outside a frame and briefly at each
    // Start, so a repeated Start restarts the select byte cleanly.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_link <= 1'b1;
        end else if (stop_det || start_ok || back_s[0]) begin
            hold_link <= 1'b1;
        end else begin
            hold_link <= standby | (pulse_cnt > 2'h1);
        end
    end

    // Power-on reset reaches the link logic without waiting for a clock.
    assign link_rst = sys_rst | hold_link;

    // ****************************************************************
    // Write hand-off from the link (system clock)
    // ****************************************************************
    eesel_sync #(.WIDTH(2), .RESET_VAL(2'h0)) u_back_sync (
        .clk(ref_clk),
        .rst(sys_rst),
        .d({xfer_tgl, deselect}),
        .q(back_s)
    );

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_d <= 1'b0;
        end else begin
            tgl_d <= back_s[1];
        end
    end

    assign wr_evt = back_s[1] ^ tgl_d;

    // The held word is stable for a whole byte time after the toggle,
    // far longer than the two-stage crossing takes.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_valid <= 1'b0;
            wr_cmd <= '0;
        end else begin
            wr_valid <= wr_evt;
            if (wr_evt) begin
                wr_cmd <= xfer_hold;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ****************************************************************
    // Link side: bit shifting on the bus clock
    // ****************************************************************
    // Pads carry pull-downs, so open straps and protect read as zero.
    eesel_sync #(.WIDTH(4), .RESET_VAL({WP_RESET, STRAP_RESET})) u_strap_sync (
        .clk(scl_link),
        .rst(link_rst),
        .d({write_protect_in, chip_sel_strap_2, chip_sel_strap_1, chip_sel_strap_0}),
        .q(strap_wp_s)
    );

    assign strap_s = strap_wp_s[2:0];
    assign wp_s = strap_wp_s[3];

    always_ff @(posedge scl_link or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt <= 4'h0;
            shreg <= 7'h00;
        end else if (bit_cnt == BIT_ACK) begin
            bit_cnt <= 4'h0;
        end else begin
            bit_cnt <= bit_cnt + 4'h1;
            shreg <= {shreg[5:0], sda_in};
        end
    end

    assign rx_byte = {shreg, sda_in};
    assign byte_done = (bit_cnt == BIT_LAST);
    assign cs_match = (rx_byte[SEL_TYPE_LSB-1:SEL_CS_LSB] == strap_s);
    assign type_mem = (rx_byte[7:SEL_TYPE_LSB] == DEV_TYPE_MEM);
    assign type_id = HAS_ID_PAGE && (rx_byte[7:SEL_TYPE_LSB] == DEV_TYPE_ID);
    assign sel_hit = cs_match & (type_mem | type_id);

    // ****************************************************************
    // Link side: byte sequencing
    // ****************************************************************
    // A read select is acknowledged, then the link waits for the next
    // Start or Stop; read data comes from outside this block.
    always_ff @(posedge scl_link or posedge link_rst) begin
        if (link_rst) begin
            state <= L_SEL;
        end else if (byte_done) begin
            case (state)
                L_SEL: begin
                    if (sel_hit && !rx_byte[SEL_RW_POS]) begin
                        state <= L_AHI;
                    end else begin
                        state <= L_IGNORE;
                    end
                end
                L_AHI: begin
                    state <= L_ALO;
                end
                L_ALO: begin
                    state <= L_DATA;
                end
                L_DATA: begin
                    state <= L_DATA;
                end
                default: begin
                    state <= L_IGNORE;
                end
            endcase
        end
    end

    always_ff @(posedge scl_link or posedge link_rst) begin
        if (link_rst) begin
            deselect <= 1'b0;
            id_page <= 1'b0;
        end else if (byte_done && state == L_SEL) begin
            deselect <= ~sel_hit;
            id_page <= type_id;
        end
    end

    // Consecutive data bytes step the address; row wrap is handled later.
    always_ff @(posedge scl_link or posedge link_rst) begin
        if (link_rst) begin
            addr <= ADDR_RESET;
        end else if (byte_done) begin
            if (state == L_AHI) begin
                addr[15:8] <= rx_byte;
            end else if (state == L_ALO) begin
                addr[7:0] <= rx_byte;
            end else if (state == L_DATA && !wp_s) begin
                addr <= (addr + 16'h0001) & ADDR_MASK;
            end
        end
    end

    always_ff @(posedge scl_link or posedge link_rst) begin
        if (link_rst) begin
            ack_pend <= 1'b0;
        end else if (byte_done) begin
            case (state)
                L_SEL: ack_pend <= sel_hit;
                L_AHI: ack_pend <= 1'b1;
                L_ALO: ack_pend <= 1'b1;
                L_DATA: ack_pend <= ~wp_s;
                default: ack_pend <= 1'b0;
            endcase
        end else if (bit_cnt == BIT_ACK) begin
            ack_pend <= 1'b0;
        end
    end

    // Pull low only in the ninth slot; changes happen while the clock is low.
    always_ff @(negedge scl_link or posedge link_rst) begin
        if (link_rst) begin
            sda_oe <= 1'b0;
        end else begin
            sda_oe <= ack_pend && (bit_cnt == BIT_ACK);
        end
    end

    // Toggle survives frame resets so no false event reaches ref_clk.
    always_ff @(posedge scl_link or posedge sys_rst) begin
        if (sys_rst) begin
            xfer_tgl <= 1'b0;
            xfer_hold <= '0;
        end else if (byte_done && state == L_DATA && !wp_s) begin
            xfer_tgl <= ~xfer_tgl;
            xfer_hold <= '{id_page: id_page, addr: addr & ADDR_MASK, data: rx_byte};
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_link_hold;
        hold_link [*2] ##1 !hold_link;
    endsequence

    property p_start_open;
        @(posedge ref_clk) disable iff (sys_rst)
        start_ok |=> !standby ##0 s_link_hold;
    endproperty
    a_start_open: assert property (p_start_open) else $error("start did not open a frame");

    property p_stop_standby;
        @(posedge ref_clk) disable iff (sys_rst)
        stop_det |=> standby && hold_link;
    endproperty
    a_stop_standby: assert property (p_stop_standby) else $error("stop left frame open");

    property p_idle_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        standby && !start_ok |=> hold_link;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("link ran outside a frame");

    property p_por_release;
        @(posedge ref_clk) disable iff (sys_rst)
        $past(sys_rst) |-> standby && hold_link && !wr_valid;
    endproperty
    a_por_release: assert property (p_por_release) else $error("bad state after reset");

    property p_low_only;
        @(posedge ref_clk) disable iff (sys_rst)
        !sda_out;
    endproperty
    a_low_only: assert property (p_low_only) else $error("data line driven high");

    property p_oe_slot;
        @(posedge scl_link) disable iff (link_rst)
        sda_oe |-> bit_cnt == BIT_ACK;
    endproperty
    a_oe_slot: assert property (p_oe_slot) else $error("ack outside ninth slot");

    sequence s_sel_good;
        state == L_SEL && byte_done && sel_hit;
    endsequence

    property p_sel_ack;
        @(posedge scl_link) disable iff (link_rst)
        s_sel_good |=> ack_pend && bit_cnt == BIT_ACK;
    endproperty
    a_sel_ack: assert property (p_sel_ack) else $error("matching select not acked");

    // Judged at the ninth rise, after the deselect has put the link back in reset
    property p_sel_miss;
        @(posedge scl_link) disable iff (sys_rst)
        state == L_SEL && byte_done && !sel_hit |=> !sda_oe && standby && hold_link;
    endproperty
    a_sel_miss: assert property (p_sel_miss) else $error("mismatched select answered");

    property p_wp_data;
        @(posedge scl_link) disable iff (link_rst)
        state == L_DATA && byte_done && wp_s |=> !ack_pend && $stable(xfer_tgl);
    endproperty
    a_wp_data: assert property (p_wp_data) else $error("protected data accepted");

    property p_wr_pulse;
        @(posedge ref_clk) disable iff (sys_rst)
        wr_evt |=> wr_valid ##1 !wr_valid;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe not one cycle");
endmodule

// File: design/eesel_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM select front end.
// Assumes: Link clock is the bus clock pin; system clock is ref_clk at 40 MHz.
// Notes: Device type codes are parameters of the top module, not constants here.
//
// Contract
// - Nothing is answered until a Start has been seen on the bus.
// - The select byte follows Start; its bit 0 is the direction, then an ack slot.
// - Select bits 7..4 must equal the built-in device type code.
// - Select bits 3..1 are expected to equal strap inputs 2..0.
// - Chip-select bits are compared one for one with the straps; mismatch means silence.
// - Unconnected straps read as zero.
// - Bytes travel most significant bit first.
// - Memory pulls data low in the ninth bit slot after each byte it accepts.
// - Write-protect high blocks every array modification.
// - Write-protect high: select and address acked, data bytes not acked.
// - Unconnected write-protect reads as low, so writes are allowed.
// - A second device type code routes the access to the identification page.
// - Location address is 16 bits, high byte then low byte.
// - Array holds 64K bytes, or 32K bytes on the smaller variant.
// - While power-on reset is asserted nothing is decoded or acked.
// - Reset release clears the interface and enters standby.
// - Reset asserting again stops all responses at once.
// - A Stop with no write cycle running returns the memory to standby.
// - Data line is only pulled low or released, never driven high.
// - Start is a data fall while the clock is high.
// - Stop is a data rise while the clock is high.
// - A select mismatch leaves the bus unacked and goes to standby.

package eesel_pkg;

    // ****************************************************************
    // Bit slot positions
    // ****************************************************************
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam int SEL_RW_POS = 0;
    localparam int SEL_CS_LSB = 1;
    localparam int SEL_TYPE_LSB = 4;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [2:0] STRAP_RESET = 3'h0;
    localparam logic WP_RESET = 1'b0;
    localparam logic [1:0] FRAME_PULSE_CYC = 2'h2;
    localparam logic [15:0] ADDR_RESET = 16'h0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        L_SEL,
        L_AHI,
        L_ALO,
        L_DATA,
        L_IGNORE
    } eesel_link_e;

    typedef struct packed {
        logic id_page;
        logic [15:0] addr;
        logic [7:0] data;
    } eesel_wr_s;

endpackage

// File: design/eesel_sync.sv
// Purpose: Two-stage synchroniser for levels entering a clock domain.
// Assumes: Each bit is an independent level or a toggle.
// Notes: Only the second stage may be read by logic.
`timescale 1ns/100ps

module eesel_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// File: testbench/eesel_master.sv
// Purpose: Behavioural two-wire bus master that drives the clock pin and pulls the data line.
// Assumes: Data line has a pull-up; this model only pulls it low or releases it.
// Notes: Timing base is a free 12 ns tick unrelated to ref_clk; clock stands high between frames.
`timescale 1ns/100ps

module eesel_master #(
    parameter int HALF = 42
) (
    output logic scl,
    output logic sda_low,
    input wire logic sda_line
);

    logic tick;

    // ****************************************************************
    // Link timing base
    // ****************************************************************
    initial begin
        tick = 1'b0;
        scl = 1'b1;
        sda_low = 1'b0;
        #3.7;
        forever #6 tick = ~tick;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge tick);
    endtask

    // ****************************************************************
    // Bus conditions
    // ****************************************************************
    task automatic start_cond();
        sda_low <= 1'b0;
        hold(HALF);
        scl <= 1'b1;
        hold(HALF);
        sda_low <= 1'b1;
        hold(HALF);
        scl <= 1'b0;
        hold(HALF);
    endtask

    task automatic stop_cond();
        hold(2);
        sda_low <= 1'b1;
        hold(HALF);
        scl <= 1'b1;
        hold(HALF);
        sda_low <= 1'b0;
        hold(HALF);
    endtask

    // Data moves only two ticks after the clock falls, never while it is high
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            scl <= 1'b0;
            hold(2);
            sda_low <= ~b[i];
            hold(HALF);
            scl <= 1'b1;
            hold(HALF);
        end
        scl <= 1'b0;
        hold(2);
        sda_low <= 1'b0;
        hold(HALF);
        scl <= 1'b1;
        hold(HALF / 2);
        ack = ~sda_line;
        hold(HALF / 2);
        scl <= 1'b0;
    endtask

    // Releases the line for eight bits, then answers in the ninth slot
    task automatic recv_byte(input logic give_ack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            scl <= 1'b0;
            hold(2);
            sda_low <= 1'b0;
            hold(HALF);
            scl <= 1'b1;
            hold(HALF / 2);
            b[i] = sda_line;
            hold(HALF - HALF / 2);
        end
        scl <= 1'b0;
        hold(2);
        sda_low <= give_ack;
        hold(HALF);
        scl <= 1'b1;
        hold(HALF);
        scl <= 1'b0;
    endtask

endmodule

// File: testbench/eesel_slave_bench.sv
// Purpose: Self-checking bench for the serial EEPROM select front end.
// Assumes: Pull-up on the data line; floating straps and write-protect are driven 0.
// Notes: Expected acks and write strobes are worked out from the select code and straps.
`timescale 1ns/100ps

module eesel_slave_bench;
    import eesel_pkg::*;

    localparam logic [3:0] TYPE_MEM = 4'h5; // Arbitrary value
    localparam logic [3:0] TYPE_ID = 4'h6; // Arbitrary value

    logic ref_clk, sys_rst, scl_link, sda_line, m_low, ack;
    logic sda_out, sda_oe, standby, wr_valid, wp, busy;
    logic [2:0] straps;
    logic [7:0] rd;
    eesel_wr_s wr_cmd;
    eesel_wr_s seen_q[$];
    int num_errors, checks;

    // Wired-AND of both pull-down drivers against the pull-up
    assign sda_line = ~(m_low | (sda_oe & ~sda_out));

    eesel_master eesel_master_inst (
        .scl(scl_link),
        .sda_low(m_low),
        .sda_line(sda_line)
    );

    eesel_slave #(
        .DEV_TYPE_MEM(TYPE_MEM),
        .DEV_TYPE_ID(TYPE_ID),
        .HAS_ID_PAGE(1'b1),
        .MEM_ADDR_W(16)
    ) eesel_slave_inst (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .scl_link(scl_link),
        .sda_in(sda_line),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .chip_sel_strap_0(straps[0]),
        .chip_sel_strap_1(straps[1]),
        .chip_sel_strap_2(straps[2]),
        .write_protect_in(wp),
        .write_busy(busy),
        .standby(standby),
        .wr_valid(wr_valid),
        .wr_cmd(wr_cmd)
    );

    // ****************************************************************
    // Clock, capture and monitors
    // ****************************************************************
    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (wr_valid === 1'b1) begin
            seen_q.push_back(wr_cmd);
        end
        if (sda_oe === 1'b1) begin
            check(32'(sda_out), 32'h0);
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One framed transfer; exp holds the expected ack per byte, select first
    task automatic xfer(input logic [7:0] sel, input int n, input logic [31:0] bytes,
                        input logic [4:0] exp);
        eesel_master_inst.start_cond();
        eesel_master_inst.send_byte(sel, ack);
        check(32'(ack), 32'(exp[0]));
        for (int i = 0; i < n; i++) begin
            eesel_master_inst.send_byte(bytes[31-8*i -: 8], ack);
            check(32'(ack), 32'(exp[i+1]));
        end
        eesel_master_inst.stop_cond();
        repeat (10) @(posedge ref_clk);
        check(32'(standby), 32'h1);
    endtask

    task automatic expect_wr(input eesel_wr_s e);
        check(32'(seen_q.size() > 0), 32'h1);
        if (seen_q.size() > 0) begin
            check(32'(seen_q.pop_front()), 32'(e));
        end
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        sys_rst = 1'b1;
        straps = 3'h0;
        wp = 1'b0;
        busy = 1'b0;
        num_errors = 0;
        checks = 0;
        repeat (5) @(posedge ref_clk);
        check(32'(standby), 32'h1);
        check(32'(sda_oe), 32'h0);
        check(32'(wr_valid), 32'h0);
        sys_rst <= 1'b0;
        repeat (5) @(posedge ref_clk);
        eesel_master_inst.send_byte({TYPE_MEM, 3'h0, 1'b0}, ack);
        check(32'(ack), 32'h0);
        eesel_master_inst.stop_cond();
        $display("test no_start done");
        for (int s = 0; s < 8; s += 5) begin
            @(posedge ref_clk);
            straps <= 3'(s);
            for (int c = 0; c < 8; c++) begin
                xfer({TYPE_MEM, 3'(c), 1'b0}, 0, 32'h0, {4'h0, c == s});
            end
        end
        $display("test strap_match done");
        xfer({TYPE_MEM, 3'h5, 1'b0}, 4, 32'hFFFFA53C, 5'h1F);
        expect_wr({1'b0, 16'hFFFF, 8'hA5});
        expect_wr({1'b0, 16'h0000, 8'h3C});
        $display("test write_wrap done");
        xfer({4'h9, 3'h5, 1'b0}, 2, 32'h12340000, 5'h0);
        xfer({TYPE_ID, 3'h5, 1'b0}, 3, 32'h00427700, 5'hF);
        expect_wr({1'b1, 16'h0042, 8'h77});
        $display("test type_codes done");
        @(posedge ref_clk);
        wp <= 1'b1;
        xfer({TYPE_MEM, 3'h5, 1'b0}, 4, 32'h01001122, 5'h07);
        check(32'(seen_q.size()), 32'h0);
        @(posedge ref_clk);
        wp <= 1'b0;
        $display("test write_protect done");
        eesel_master_inst.start_cond();
        eesel_master_inst.send_byte({TYPE_MEM, 3'h5, 1'b1}, ack);
        check(32'(ack), 32'h1);
        eesel_master_inst.recv_byte(1'b0, rd);
        check(32'(rd), 32'hFF);
        eesel_master_inst.stop_cond();
        repeat (10) @(posedge ref_clk);
        check(32'(standby), 32'h1);
        @(posedge ref_clk);
        busy <= 1'b1;
        xfer({TYPE_MEM, 3'h5, 1'b0}, 0, 32'h0, 5'h0);
        @(posedge ref_clk);
        busy <= 1'b0;
        $display("test read_busy done");
        eesel_master_inst.start_cond();
        eesel_master_inst.send_byte({TYPE_MEM, 3'h5, 1'b0}, ack);
        check(32'(ack), 32'h1);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        eesel_master_inst.send_byte(8'h00, ack);
        check(32'(ack), 32'h0);
        check(32'(sda_oe), 32'h0);
        eesel_master_inst.stop_cond();
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge ref_clk);
        xfer({TYPE_MEM, 3'h5, 1'b0}, 3, 32'h00105A00, 5'hF);
        expect_wr({1'b0, 16'h0010, 8'h5A});
        check(32'(seen_q.size()), 32'h0);
        $display("test reset_midframe done");
        wrap_up();
    end

    // Whole run needs well under 1 ms of bus time
    initial begin
        #2_000_000;
        num_errors++;
        wrap_up();
    end

endmodule
